// >>> bfr_framer.sv
// binary record framer with host rate-change handshake
//
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module bfr_framer
  import bfr_pkg::*;
#(
  parameter longint REVERT_CYCLES = REVERT_CYCLES_L
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  input wire logic [7:0] rxData,
  input wire logic rxValid,
  output logic [7:0] txData,
  output logic txValid,
  input wire logic txReady,
  output logic [2:0] baudSel
);

  typedef enum logic [2:0] {
    TX_IDLE, TX_BODY, TX_SUM, TX_CLOSE, TX_END
  } bfr_tx_e;
  typedef enum logic [1:0] {RX_DAT, RX_ESC, RX_END} bfr_rx_e;
  typedef enum logic [1:0] {
    HS_IDLE, HS_ACKED, HS_OFFERED, HS_CONFIRM
  } bfr_hs_e;

  // nearest table rate not above the request, index 0 when the request is below the whole table
  function automatic logic [2:0] pickRate(input logic [31:0] req);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = 0; i < RATE_COUNT; i++) begin
      if (req >= 32'(RATE_NOMINAL[i])) begin
        idx = 3'(i);
      end
    end
    return idx;
  endfunction

  // achievable rate reported for a table index
  function automatic logic [31:0] rateValue(input logic [2:0] idx);
    logic [31:0] v;
    v = 32'h0;
    for (int i = 0; i < RATE_COUNT; i++) begin
      if (idx == 3'(i)) begin
        v = achievedRate(RATE_NOMINAL[i]);
      end
    end
    return v;
  endfunction

  logic [7:0] payMem [256];
  logic usbMode;
  logic sendPend;
  bfr_packet_s record;
  logic [7:0] bufAddr;
  logic [3:0] satChan;
  logic [7:0] satVid;
  logic [15:0] satSnr;
  logic badVid;
  bfr_tx_e txState;
  logic fromResp;
  bfr_packet_s curPkt;
  logic [8:0] bodyIdx;
  logic [7:0] txSum;
  logic dupPend;
  logic [7:0] curByte;
  logic loadOk;
  logic takeFrame;
  bfr_rx_e rxState;
  logic [7:0] rxCnt;
  logic [7:0] rxSum;
  bfr_packet_s rxPkt;
  logic rxStore;
  logic rxFrameOk;
  logic [7:0] rxErrCount;
  bfr_packet_s resp;
  logic respPend;
  logic respSet;
  bfr_packet_s next_resp;
  bfr_hs_e hsState;
  logic [1:0] pingCount;
  logic [31:0] revertTimer;
  logic [2:0] pendIdx;
  bfr_sat_entry_s satEntry;
  logic [7:0] satBase;

  assign loadOk = !txValid || txReady;
  assign takeFrame = (txState == TX_IDLE) && loadOk && (respPend || sendPend);

  // control register, record header and buffer pointer
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      usbMode <= 1'b0;
      sendPend <= 1'b0;
      record <= '0;
      bufAddr <= RESET_BYTE;
      satChan <= 4'h0;
      satVid <= RESET_BYTE;
      satSnr <= 16'h0000;
    end else begin
      if (takeFrame && !respPend) begin
        sendPend <= 1'b0;
      end
      if (regWr) begin
        unique case (regAddr)
          REG_CTRL: begin
            usbMode <= regWdata[CTRL_USB];
            if (regWdata[CTRL_SEND]) begin
              sendPend <= 1'b1;
            end
            if (regWdata[CTRL_SAT_PRESET]) begin
              record.id <= ID_SAT;
              record.len <= LEN_SAT;
            end
          end
          REG_RECORD: begin
            record.id <= regWdata[7:0];
            record.len <= regWdata[15:8];
          end
          REG_BUF_ADDR: bufAddr <= regWdata[7:0];
          REG_BUF_DATA: bufAddr <= bufAddr + 8'h01;
          REG_SAT_A: begin
            satChan <= regWdata[3:0];
            satVid <= regWdata[15:8];
            satSnr <= regWdata[31:16];
          end
          default: begin
          end
        endcase
      end
    end
  end

  // one satellite entry packed low byte first
  always_comb begin
    satEntry.vid = satVid;
    satEntry.snr = satSnr;
    satEntry.elevation = regWdata[7:0];
    satEntry.azimuth = regWdata[23:8];
    satEntry.flags = 8'h00;
    satEntry.flags[FLAG_EPHEMERIS] = regWdata[24];
    satEntry.flags[FLAG_DIFFERENTIAL] = regWdata[25];
    satEntry.flags[FLAG_IN_SOLUTION] = regWdata[26];
    satBase = 8'(satChan * SAT_ENTRY_BYTES);
  end

  // payload buffer: raw bytes or satellite entries
  always_ff @(posedge clk_sys) begin
    if (regWr && regAddr == REG_BUF_DATA) begin
      payMem[bufAddr] <= regWdata[7:0];
    end else if (regWr && regAddr == REG_SAT_B &&
                 32'(satChan) < SAT_CHANNELS) begin
      for (int k = 0; k < SAT_ENTRY_BYTES; k++) begin
        payMem[8'(satBase + 8'(k))] <= satEntry[k*8 +: 8];
      end
    end
  end

  // sticky flag for a vehicle id outside 1..64
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      badVid <= 1'b0;
    end else if (regWr && regAddr == REG_SAT_B) begin
      if (satVid < VID_MIN || satVid > VID_MAX) begin
        badVid <= 1'b1;
      end
    end else if (regWr && regAddr == REG_STATUS && regWdata[0]) begin
      badVid <= 1'b0;
    end
  end

  // byte of the frame body at the current index
  always_comb begin
    curByte = RESET_BYTE;
    if (bodyIdx == 9'h000) begin
      curByte = curPkt.id;
    end else if (bodyIdx == 9'h001) begin
      curByte = curPkt.len;
    end else if (fromResp) begin
      curByte = curPkt.payload[2'(bodyIdx - 9'h002) * 8 +: 8];
    end else begin
      curByte = payMem[8'(bodyIdx - 9'h002)];
    end
  end

  // transmit sequencer with stuffing and checksum
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      txState <= TX_IDLE;
      txValid <= 1'b0;
      txData <= RESET_BYTE;
      fromResp <= 1'b0;
      curPkt <= '0;
      bodyIdx <= 9'h000;
      txSum <= RESET_BYTE;
      dupPend <= 1'b0;
    end else if (loadOk) begin
      unique case (txState)
        TX_IDLE: begin
          txValid <= 1'b0;
          dupPend <= 1'b0;
          bodyIdx <= 9'h000;
          txSum <= RESET_BYTE;
          if (takeFrame) begin
            fromResp <= respPend;
            curPkt <= respPend ? resp : record;
            txState <= TX_BODY;
            if (!usbMode) begin
              txData <= BYTE_DLE;
              txValid <= 1'b1;
            end
          end
        end
        TX_BODY: begin
          txValid <= 1'b1;
          if (dupPend) begin
            txData <= BYTE_DLE;
            dupPend <= 1'b0;
            if (bodyIdx == {1'b0, curPkt.len} + 9'h002) begin
              txState <= TX_SUM;
            end
          end else begin
            txData <= curByte;
            txSum <= txSum + curByte;
            dupPend <= !usbMode && curByte == BYTE_DLE;
            bodyIdx <= bodyIdx + 9'h001;
            if (bodyIdx == {1'b0, curPkt.len} + 9'h001 &&
                !(!usbMode && curByte == BYTE_DLE)) begin
              txState <= usbMode ? TX_IDLE : TX_SUM;
            end
          end
        end
        TX_SUM: begin
          txValid <= 1'b1;
          if (dupPend) begin
            txData <= BYTE_DLE;
            dupPend <= 1'b0;
            txState <= TX_CLOSE;
          end else begin
            txData <= 8'(-txSum);
            dupPend <= 8'(-txSum) == BYTE_DLE;
            if (8'(-txSum) != BYTE_DLE) begin
              txState <= TX_CLOSE;
            end
          end
        end
        TX_CLOSE: begin
          txData <= BYTE_DLE;
          txValid <= 1'b1;
          txState <= TX_END;
        end
        TX_END: begin
          txData <= BYTE_ETX;
          txValid <= 1'b1;
          txState <= TX_IDLE;
        end
      endcase
    end
  end

  // incoming bytes kept after de-stuffing
  assign rxStore = rxValid &&
                   ((rxState == RX_DAT && rxData != BYTE_DLE) ||
                    (rxState == RX_ESC && rxData != BYTE_ETX));
  assign rxFrameOk = rxValid && rxState == RX_ESC && rxData == BYTE_ETX &&
                     rxSum == 8'h00 && rxCnt == rxPkt.len + 8'h03;

  // receive de-stuffer and frame collector
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      rxState <= RX_END;
      rxCnt <= RESET_BYTE;
      rxSum <= RESET_BYTE;
      rxPkt <= '0;
      rxErrCount <= RESET_BYTE;
    end else if (rxValid) begin
      unique case (rxState)
        RX_DAT: begin
          if (rxData == BYTE_DLE) begin
            rxState <= RX_ESC;
          end
        end
        RX_ESC: begin
          rxState <= (rxData == BYTE_ETX) ? RX_END : RX_DAT;
        end
        RX_END: begin
          if (rxData == BYTE_DLE) begin
            rxState <= RX_ESC;
          end
        end
      endcase
      if (rxState == RX_ESC && rxData == BYTE_ETX) begin
        rxCnt <= RESET_BYTE;
        rxSum <= RESET_BYTE;
        if (!rxFrameOk) begin
          rxErrCount <= rxErrCount + 8'h01;
        end
      end else if (rxStore) begin
        rxCnt <= rxCnt + 8'h01;
        rxSum <= rxSum + rxData;
        if (rxCnt == 8'h00) begin
          rxPkt.id <= rxData;
        end else if (rxCnt == 8'h01) begin
          rxPkt.len <= rxData;
          rxPkt.payload <= 32'h0;
        end else if (rxCnt < 8'h06) begin
          rxPkt.payload[2'(rxCnt - 8'h02) * 8 +: 8] <= rxData;
        end
      end
    end
  end

  // decode of a complete host packet into a reply
  always_comb begin
    respSet = 1'b0;
    next_resp = '0;
    if (rxFrameOk) begin
      if (rxPkt.id == ID_REQUEST_CONTROL && rxPkt.len == 8'h02 &&
          rxPkt.payload[15:0] == 16'h0000) begin
        respSet = 1'b1;
        next_resp.id = ID_ACKNOWLEDGE;
        next_resp.len = 8'h01;
        next_resp.payload = {24'h0, ID_REQUEST_CONTROL};
      end else if (rxPkt.id == ID_RATE_REQUEST && rxPkt.len == 8'h04 &&
                   hsState == HS_ACKED) begin
        respSet = 1'b1;
        next_resp.id = ID_RATE_REQUEST;
        next_resp.len = 8'h04;
        next_resp.payload = rateValue(pickRate(rxPkt.payload));
      end else if (rxPkt.id == ID_COMMAND && rxPkt.len != 8'h00 &&
                   rxPkt.payload[7:0] == PING_CODE) begin
        respSet = 1'b1;
        next_resp.id = ID_ACKNOWLEDGE;
        next_resp.len = 8'h01;
        next_resp.payload = {24'h0, ID_COMMAND};
      end
    end
  end

  // pending reply, a new one wins over its own take
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      respPend <= 1'b0;
      resp <= '0;
    end else if (respSet) begin
      respPend <= 1'b1;
      resp <= next_resp;
    end else if (takeFrame) begin
      respPend <= 1'b0;
    end
  end

  // rate-change handshake and revert timer
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      hsState <= HS_IDLE;
      baudSel <= RATE_DEFAULT_IDX;
      pendIdx <= RATE_DEFAULT_IDX;
      pingCount <= 2'h0;
      revertTimer <= 32'h0;
    end else begin
      unique case (hsState)
        HS_IDLE: begin
          if (respSet && rxPkt.id == ID_REQUEST_CONTROL) begin
            hsState <= HS_ACKED;
          end
        end
        HS_ACKED: begin
          if (respSet && rxPkt.id == ID_RATE_REQUEST) begin
            pendIdx <= pickRate(rxPkt.payload);
            hsState <= HS_OFFERED;
          end
        end
        HS_OFFERED: begin
          if (rxFrameOk && rxPkt.id == ID_ACKNOWLEDGE &&
              rxPkt.len != 8'h00 &&
              rxPkt.payload[7:0] == RATE_ACCEPT_CODE) begin
            baudSel <= pendIdx;
            pingCount <= 2'h0;
            revertTimer <= 32'h0;
            hsState <= HS_CONFIRM;
          end else if (respSet && rxPkt.id == ID_REQUEST_CONTROL) begin
            hsState <= HS_ACKED;
          end
        end
        HS_CONFIRM: begin
          revertTimer <= revertTimer + 32'h1;
          if (respSet && rxPkt.id == ID_COMMAND) begin
            pingCount <= pingCount + 2'h1;
            if (pingCount == 2'h1) begin
              hsState <= HS_IDLE;
            end
          end else if (64'(revertTimer) >= REVERT_CYCLES - 1) begin
            baudSel <= RATE_DEFAULT_IDX;
            hsState <= HS_IDLE;
          end
        end
      endcase
    end
  end

  // register read port, data valid for one cycle
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      regRdata <= 32'h0;
    end else if (regRd) begin
      unique case (regAddr)
        REG_CTRL: regRdata <= {29'h0, 1'b0, sendPend, usbMode};
        REG_STATUS: regRdata <= {8'h0, rxErrCount, 6'h0, pingCount,
                                 2'(hsState), baudSel, respPend,
                                 txState != TX_IDLE || txValid, badVid};
        REG_RECORD: regRdata <= {16'h0, record.len, record.id};
        REG_BUF_ADDR: regRdata <= {24'h0, bufAddr};
        REG_SAT_A: regRdata <= {satSnr, satVid, 4'h0, satChan};
        default: regRdata <= 32'h0;
      endcase
    end else begin
      regRdata <= 32'h0;
    end
  end

endmodule
`default_nettype wire

// >>> bfr_pkg.sv
// package for the binary record framer and rate-change handshake
package bfr_pkg;

  // clock and timing
  localparam int CLK_HZ = 250_000_000;
  localparam int REVERT_TIME_MS = 2000;
  localparam longint REVERT_CYCLES_L = longint'(REVERT_TIME_MS) * CLK_HZ / 1000;
  localparam int UART_OVERSAMPLE = 16;

  // framing bytes
  localparam logic [7:0] BYTE_DLE = 8'h10;
  localparam logic [7:0] BYTE_ETX = 8'h03;

  // record and packet identifiers
  localparam logic [7:0] ID_SAT = 8'h72;
  localparam logic [7:0] LEN_SAT = 8'h54;
  localparam logic [7:0] ID_POS = 8'h33;
  localparam logic [7:0] ID_MEAS = 8'h34;
  localparam logic [7:0] ID_REQUEST_CONTROL = 8'h1C;
  localparam logic [7:0] ID_ACKNOWLEDGE = 8'h06;
  localparam logic [7:0] ID_RATE_REQUEST = 8'h30;
  localparam logic [7:0] ID_COMMAND = 8'h0A;
  localparam logic [7:0] RATE_ACCEPT_CODE = 8'h31;
  localparam logic [7:0] PING_CODE = 8'h3A;

  // satellite channel layout
  localparam int SAT_CHANNELS = 12;
  localparam int SAT_ENTRY_BYTES = 7;
  localparam int FLAG_EPHEMERIS = 0;
  localparam int FLAG_DIFFERENTIAL = 1;
  localparam int FLAG_IN_SOLUTION = 2;
  localparam logic [7:0] VID_MIN = 8'h01;
  localparam logic [7:0] VID_MAX = 8'h40;

  // register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_RECORD = 8'h08;
  localparam logic [7:0] REG_BUF_ADDR = 8'h0C;
  localparam logic [7:0] REG_BUF_DATA = 8'h10;
  localparam logic [7:0] REG_SAT_A = 8'h14;
  localparam logic [7:0] REG_SAT_B = 8'h18;
  localparam int CTRL_USB = 0;
  localparam int CTRL_SEND = 1;
  localparam int CTRL_SAT_PRESET = 2;

  // serial rate table, index 1 is the default rate
  localparam int RATE_COUNT = 5;
  localparam logic [2:0] RATE_DEFAULT_IDX = 3'h1;
  localparam int RATE_NOMINAL [RATE_COUNT] = '{4800, 9600, 19200, 38400, 57600};

  // rate actually reachable by an integer divider
  function automatic logic [31:0] achievedRate(input int nominal);
    int div;
    div = CLK_HZ / (UART_OVERSAMPLE * nominal);
    return 32'(CLK_HZ / (UART_OVERSAMPLE * div));
  endfunction

  // reset values
  localparam logic [7:0] RESET_BYTE = 8'h00;

  typedef struct packed {
    logic [7:0] flags;
    logic [15:0] azimuth;
    logic [7:0] elevation;
    logic [15:0] snr;
    logic [7:0] vid;
  } bfr_sat_entry_s;

  typedef struct packed {
    logic [7:0] id;
    logic [7:0] len;
    logic [31:0] payload;
  } bfr_packet_s;

endpackage

// >>> bfr_framer_end.sv
// empty unit, holds no logic of the framer
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// >>> bfr_framer_monitor.sv
// port checker for the binary record framer
`timescale 1ns/1ps
`default_nettype none
module bfr_framer_monitor
  import bfr_pkg::*;
#(
  parameter longint REVERT_CYCLES = 200
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [31:0] regRdata,
  input wire logic [7:0] rxData,
  input wire logic rxValid,
  input wire logic [7:0] txData,
  input wire logic txValid,
  input wire logic txReady,
  input wire logic [2:0] baudSel
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  logic usbQ;
  logic etxSeen;
  longint held;
  // closing byte of a host frame
  assign etxSeen = rxValid && (rxData == BYTE_ETX);
  // usb mode copy and cycles since the rate last moved
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      usbQ <= 1'b0;
      held <= 64'sd0;
    end else begin
      if (regWr && regAddr == REG_CTRL) usbQ <= regWdata[CTRL_USB];
      held <= $changed(baudSel) ? 64'sd1 : held + 64'sd1;
    end
  end
  a_tx_hold_stall: assert property (
    txValid && !txReady |=> txValid && $stable(txData))
    else $error("tx byte dropped or changed while stalled");
  a_read_quiet: assert property (!regRd |=> regRdata == 32'h0)
    else $error("read data outside its slot");
  a_buf_reads_zero: assert property (
    regRd && regAddr == REG_BUF_DATA |=> regRdata == 32'h0)
    else $error("buffer data port not write only");
  a_status_rate: assert property (
    regRd && regAddr == REG_STATUS |=> regRdata[5:3] == $past(baudSel))
    else $error("status rate field wrong");
  a_rate_legal: assert property (baudSel <= 3'h4)
    else $error("rate index out of table");
  a_send_start: assert property (
    regWr && regAddr == REG_CTRL && regWdata[CTRL_SEND] && !usbQ &&
    !regWdata[CTRL_USB] && !txValid |-> ##2 txValid && txData == BYTE_DLE)
    else $error("record did not open with delimiter");
  a_rate_cause: assert property (
    $changed(baudSel) && baudSel != RATE_DEFAULT_IDX |->
    $past(etxSeen) || $past(etxSeen, 2))
    else $error("rate moved without a host frame");
  a_revert_window: assert property (
    $changed(baudSel) && baudSel == RATE_DEFAULT_IDX && !$past(rxValid) &&
    !$past(rxValid, 2) |->
    held >= REVERT_CYCLES - 3 && held <= REVERT_CYCLES + 3)
    else $error("rate revert at wrong time");
endmodule
`default_nettype wire

// >>> bfr_host_model.sv
// host side model: frame sender and stuffed byte sink
`timescale 1ns/1ps
`default_nettype none
module bfr_host_model
  import bfr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic slow,
  input wire logic [7:0] txData,
  input wire logic txValid,
  output logic txReady,
  output var logic [7:0] rxData,
  output var logic rxValid
);
  logic [7:0] rawQ[$];
  logic [7:0] wq[$];
  logic [7:0] que[256];
  logic [7:0] inPtr;
  logic [1:0] st;
  logic tick;
  initial begin
    rxData = 8'h00;
    rxValid = 1'b0;
  end
  // sink stalls every other cycle when slow
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      tick <= 1'b0;
      txReady <= 1'b0;
    end else begin
      tick <= ~tick;
      txReady <= !slow || tick;
    end
  end
  // record raw bytes and strip the stuffing
  always @(posedge clk_sys) begin
    if (reset) begin
      st <= 2'd2;
      inPtr <= 8'h00;
    end else if (txValid && txReady) begin
      rawQ.push_back(txData);
      if (st == 2'd0 && txData == BYTE_DLE) st <= 2'd1;
      else if (st == 2'd1 && txData == BYTE_ETX) st <= 2'd2;
      else if (st == 2'd2) st <= (txData == BYTE_DLE) ? 2'd1 : 2'd2;
      else begin
        st <= 2'd0;
        que[inPtr] <= txData;
        inPtr <= inPtr + 8'h01;
      end
    end
  end
  // build a link frame, checksum optionally spoiled
  task automatic wrap(input logic [7:0] q[$], input logic usb,
    input logic bad);
    logic [7:0] s;
    s = 8'h00;
    wq.delete();
    foreach (q[i]) s = s - q[i];
    if (usb) wq = q;
    else begin
      q.push_back(s ^ {7'h0, bad});
      wq.push_back(BYTE_DLE);
      foreach (q[i]) begin
        wq.push_back(q[i]);
        if (q[i] == BYTE_DLE) wq.push_back(BYTE_DLE);
      end
      wq.push_back(BYTE_DLE);
      wq.push_back(BYTE_ETX);
    end
  endtask
  // send one host frame, then release the line
  task automatic sendFrame(input logic [7:0] q[$], input logic bad);
    wrap(q, 1'b0, bad);
    foreach (wq[i]) begin
      rxData <= wq[i];
      rxValid <= 1'b1;
      @(posedge clk_sys);
    end
    rxValid <= 1'b0;
    rxData <= ~wq[wq.size()-1];
  endtask
endmodule
`default_nettype wire

// >>> test_bfr_framer.sv
// self-checking bench for the binary record framer
`timescale 1ns/1ps
`default_nettype none
module test_bfr_framer
  import bfr_pkg::*;
;
  localparam longint REV = 200;
  logic clk_sys, reset, regWr, regRd, rxValid, txReady, txValid, slow;
  logic [7:0] regAddr, rxData, txData, id;
  logic [31:0] regWdata, regRdata, d;
  logic [2:0] baudSel;
  logic [7:0] p[$];
  int failures = 0;
  int checks = 0;
  int cyc = 0;
  bfr_framer #(.REVERT_CYCLES(REV)) u_bfr_framer (.clk_sys(clk_sys),
    .reset(reset), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata(regRdata), .rxData(rxData), .rxValid(rxValid),
    .txData(txData), .txValid(txValid), .txReady(txReady),
    .baudSel(baudSel));
  bfr_host_model u_bfr_host_model (.clk_sys(clk_sys), .reset(reset),
    .slow(slow), .txData(txData), .txValid(txValid), .txReady(txReady),
    .rxData(rxData), .rxValid(rxValid));
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic report_and_stop();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 60000) begin
      failures++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    regAddr <= a;
    regWdata <= v;
    regWr <= 1'b1;
    @(posedge clk_sys);
    regWr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1 v = regRdata;
    @(posedge clk_sys);
  endtask
  task automatic send(input logic bad);
    u_bfr_host_model.sendFrame(p, bad);
  endtask
  // wait for the expected frame p and compare byte by byte
  task automatic expectQ(input logic usb);
    int n;
    n = 0;
    u_bfr_host_model.wrap(p, usb, 1'b0);
    while (u_bfr_host_model.rawQ.size() < u_bfr_host_model.wq.size() &&
      n < 5000) begin
      @(posedge clk_sys);
      n++;
    end
    repeat (4) @(posedge clk_sys);
    chk(u_bfr_host_model.rawQ.size(), u_bfr_host_model.wq.size());
    foreach (u_bfr_host_model.wq[i])
      chk(u_bfr_host_model.rawQ[i], u_bfr_host_model.wq[i]);
    u_bfr_host_model.rawQ.delete();
  endtask
  task automatic ping();
    p = {ID_COMMAND, 8'h01, PING_CODE};
    send(1'b0);
    p = {ID_ACKNOWLEDGE, 8'h01, ID_COMMAND};
    expectQ(1'b0);
  endtask
  // rate change handshake followed by the first ping
  task automatic hs(input int rate, input logic [2:0] idx);
    int a;
    a = CLK_HZ / (UART_OVERSAMPLE * (CLK_HZ / (UART_OVERSAMPLE * rate)));
    chk(32'(a * 20 >= rate * 19 && a * 20 <= rate * 21), 32'h1);
    p = {ID_REQUEST_CONTROL, 8'h02, 8'h00, 8'h00};
    send(1'b0);
    p = {ID_ACKNOWLEDGE, 8'h01, ID_REQUEST_CONTROL};
    expectQ(1'b0);
    p = {ID_RATE_REQUEST, 8'h04, 8'(rate), 8'(rate >> 8), 8'(rate >> 16),
      8'(rate >> 24)};
    send(1'b0);
    p = {ID_RATE_REQUEST, 8'h04, 8'(a), 8'(a >> 8), 8'(a >> 16), 8'(a >> 24)};
    expectQ(1'b0);
    p = {ID_ACKNOWLEDGE, 8'h01, RATE_ACCEPT_CODE};
    send(1'b0);
    repeat (8) @(posedge clk_sys);
    chk(32'(baudSel), 32'(idx));
    ping();
  endtask
  // main sequence
  initial begin
    reset = 1'b1;
    regAddr = 8'h00;
    regWdata = 32'h0;
    regWr = 1'b0;
    regRd = 1'b0;
    slow = 1'b0;
    repeat (16) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    wr(REG_CTRL, 32'h4);
    p = {ID_SAT, LEN_SAT};
    for (int i = 0; i < 12; i++) begin
      wr(REG_SAT_A, {16'h1000 | 16'(i), 8'(i * 5 + 1), 8'(i)});
      wr(REG_SAT_B, {5'h0, 3'(i), 16'h0100 | 16'(i), 8'h20 + 8'(i)});
      p = {p, 8'(i * 5 + 1), 8'(i), 8'h10, 8'h20 + 8'(i), 8'(i), 8'h01,
        8'(i & 7)};
    end
    wr(REG_CTRL, 32'h2);
    expectQ(1'b0);
    $display("test satellite record done");
    wr(REG_CTRL, 32'h1);
    wr(REG_CTRL, 32'h3);
    wr(REG_CTRL, 32'h3);
    p = {p, p};
    expectQ(1'b1);
    wr(REG_CTRL, 32'h0);
    $display("test usb record done");
    slow <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      id = k ? ID_MEAS : ID_POS;
      wr(REG_RECORD, {16'h0, 8'h04, id});
      wr(REG_BUF_ADDR, 32'h0);
      p = {id, 8'h04, 8'h10, 8'h01, 8'h02, 8'hA6};
      for (int j = 2; j < 6; j++) wr(REG_BUF_DATA, 32'(p[j]));
      rd(REG_RECORD, d);
      chk(d, {16'h0, 8'h04, id});
      wr(REG_CTRL, 32'h2);
      expectQ(1'b0);
    end
    slow <= 1'b0;
    rd(8'h20, d);
    chk(d, 32'h0);
    rd(REG_BUF_DATA, d);
    chk(d, 32'h0);
    $display("test stalled records done");
    p = {ID_COMMAND, 8'h01, PING_CODE};
    send(1'b1);
    repeat (100) @(posedge clk_sys);
    chk(u_bfr_host_model.rawQ.size(), 32'h0);
    rd(REG_STATUS, d);
    chk(d[23:16], 32'h1);
    wr(REG_SAT_A, 32'h00004100);
    wr(REG_SAT_B, 32'h0);
    rd(REG_STATUS, d);
    chk(d[0], 32'h1);
    wr(REG_STATUS, 32'h1);
    rd(REG_STATUS, d);
    chk(d[0], 32'h0);
    $display("test refusals done");
    hs(38400, 3'h3);
    ping();
    repeat (REV + 20) @(posedge clk_sys);
    chk(32'(baudSel), 32'h3);
    hs(19200, 3'h2);
    repeat (REV / 2) @(posedge clk_sys);
    chk(32'(baudSel), 32'h2);
    repeat (REV) @(posedge clk_sys);
    chk(32'(baudSel), 32'h1);
    $display("test rate handshake done");
    report_and_stop();
  end
endmodule
bind bfr_framer bfr_framer_monitor #(.REVERT_CYCLES(REVERT_CYCLES)) u_mon (
  .clk_sys(clk_sys), .reset(reset), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
  .rxData(rxData), .rxValid(rxValid), .txData(txData), .txValid(txValid),
  .txReady(txReady), .baudSel(baudSel));
`default_nettype wire
